/* verilog/pulse_count_switch_decoder.v */
// pulse-count decoder driving three or six low-side switch controls
// assumes the control pin is asynchronous to clk; outputs are on-commands
`timescale 1ns/1ps
`default_nettype none
`include "pulse_switch_regs.vh"
module pulse_count_switch_decoder #(
   parameter NUM_SW          = `NUM_SWITCHES,    // 3 or 6 outputs
   parameter LATCH_DELAY_CYC = `LATCH_DELAY_CYC, // pin-high cycles to latch
   parameter OFF_TIMEOUT_CYC = `OFF_TIMEOUT_CYC  // pin-low cycles to shut down
) (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // control pin from host
   input  wire pulse_pin,
   // switch controls, high = switch closed (on)
   output wire switch_out_a,
   output wire switch_out_b,
   output wire switch_out_c,
   output wire switch_out_d,
   output wire switch_out_e,
   output wire switch_out_f,
   // device enabled status
   output reg  enabled
);
   // timer width; wide enough for the longest default delay
   localparam TW = `TIMER_W;
   // pattern width; the six-output variant uses every bit
   localparam PW = `SW_MAX;
   // counter mask: picks the wrap point and the switches in use
   localparam [PW-1:0] COUNT_MASK = (NUM_SW == `THREE_SW) ? `MASK_THREE : `MASK_SIX;
   // last high-timer value before the latch fires
   localparam [31:0] LATCH_LIMIT = LATCH_DELAY_CYC - 1;
   // last low-timer value before the shutdown fires
   localparam [31:0] OFF_LIMIT = OFF_TIMEOUT_CYC - 1;

   // pin path
   wire           pin_level;    // filtered pin level
   reg            pin_prev;     // filtered level one cycle back
   wire           rise;         // filtered rising edge
   wire           fall;         // filtered falling edge

   // counting and pattern
   reg  [PW-1:0]  count_m1;     // pulse count minus one, masked to the variant
   reg  [PW-1:0]  next_count;   // count after this cycle's events
   wire [PW-1:0]  decoded_on;   // count decoded into on-bits
   reg  [PW-1:0]  on_pattern;   // latched pattern, set bit = switch on

   // timers
   reg  [TW-1:0]  high_timer;   // cycles the pin has stayed high
   reg  [TW-1:0]  low_timer;    // cycles the pin has stayed low
   reg            latched;      // this high period has already latched
   wire           latch_due;    // high timer reached the latch delay
   wire           off_due;      // low timer reached the off timeout

   // qualified events
   wire           wake;         // first rising edge while shut down
   wire           latch_now;    // pattern transfer in this cycle
   wire           shut_now;     // shutdown in this cycle

   // synchroniser for the asynchronous pin
   pin_sync u_sync (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_async (pulse_pin),
      .pin_level (pin_level)
   );

   // true once a timer has counted up to its limit
   function reached;
      input [TW-1:0] timer;
      input [31:0]   limit;
      begin
         // zero-extend the timer so both sides compare at 32 bits
         reached = ({{(32-TW){1'b0}}, timer} >= limit);
      end
   endfunction

   // step the counter by one and wrap it to the variant's range
   function [PW-1:0] advance;
      input [PW-1:0] c;
      begin
         // masking makes the three-output counter roll over after eight
         advance = (c + `COUNT_STEP) & COUNT_MASK;
      end
   endfunction

   // remember the filtered level; idle low matches the reset value
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_level;
      end
   end

   // edges of the filtered pin
   assign rise = pin_level & ~pin_prev;
   assign fall = ~pin_level & pin_prev;

   // timer comparisons, each used by several processes
   assign latch_due = reached(high_timer, LATCH_LIMIT);
   assign off_due   = reached(low_timer, OFF_LIMIT);

   // event qualification
   assign wake      = rise & ~enabled;
   // latch only while the pin is held high and once per high period
   assign latch_now = pin_level & ~rise & ~latched & enabled & latch_due;
   // shut down only while the pin is held low, never on the falling edge
   assign shut_now  = ~pin_level & ~fall & enabled & off_due;

   // next count: restart at count one after shutdown, else accumulate
   always @* begin
      next_count = count_m1;                  // hold by default
      if (wake) begin
         next_count = `COUNT_FIRST;
      end else if (rise) begin
         next_count = advance(count_m1);
      end else if (shut_now) begin
         next_count = `COUNT_FIRST;           // cleared while shut down
      end
   end

   // pulse counter register
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_m1 <= `COUNT_FIRST;
      end else begin
         count_m1 <= next_count;
      end
   end

   // high timer: restarts on each rising edge, counts while held high
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_timer <= {TW{1'b0}};
      end else if (rise) begin
         high_timer <= {TW{1'b0}};
      end else if (pin_level && !latched && enabled && !latch_due) begin
         // stops at the limit, so it cannot wrap on a long high
         high_timer <= high_timer + 1'b1;
      end
   end

   // low timer: restarts on each falling edge, counts while held low
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_timer <= {TW{1'b0}};
      end else if (fall) begin
         low_timer <= {TW{1'b0}};
      end else if (!pin_level && enabled && !off_due) begin
         // stops at the limit while enabled
         low_timer <= low_timer + 1'b1;
      end
   end

   // latch marker: one transfer per high period
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched <= 1'b0;
      end else if (rise) begin
         // a new edge opens a new high period
         latched <= 1'b0;
      end else if (latch_now) begin
         latched <= 1'b1;
      end else if (shut_now) begin
         latched <= 1'b0;
      end
   end

   // enable state
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enabled <= 1'b0;
      end else if (wake) begin
         // first edge after shutdown enables the device
         enabled <= 1'b1;
      end else if (shut_now) begin
         // pin low for the off timeout disables it
         enabled <= 1'b0;
      end
   end

   // decode: a set count bit opens its switch; unused switches stay open
   genvar gi;
   generate
      for (gi = 0; gi < PW; gi = gi + 1) begin : g_decode
         assign decoded_on[gi] = COUNT_MASK[gi] & ~count_m1[gi];
      end
   endgenerate

   // latched output pattern, set bit = switch closed
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_pattern <= `PATTERN_NONE;
      end else if (wake) begin
         // every switch of the variant turns on at once
         on_pattern <= COUNT_MASK;
      end else if (latch_now) begin
         // counted value reaches the switches only after the delay
         on_pattern <= decoded_on;
      end else if (shut_now) begin
         // all switches open on shutdown
         on_pattern <= `PATTERN_NONE;
      end
   end

   // outputs straight from the pattern flip-flops, a = least bit
   assign switch_out_a = on_pattern[0];
   assign switch_out_b = on_pattern[1];
   assign switch_out_c = on_pattern[2];
   assign switch_out_d = on_pattern[3];
   assign switch_out_e = on_pattern[4];
   assign switch_out_f = on_pattern[5];
endmodule
`default_nettype wire

/* verilog/pulse_switch_regs.vh */
// timing constants and code values for the pulse-count switch decoder
// assumes a 125 MHz core clock; included by the decoder file
//
// Behaviour
// - each pin rising edge advances pulse counter
// - three outputs give 8, six give 64
// - three-output counter wraps after eight edges
// - three outputs show count minus one, set=off
// - six outputs show count minus one, set=off
// - pattern latched after pin high latch_delay
// - first edge after shutdown enables, all on
// - pin low 500us disables, switches open
`ifndef PULSE_SWITCH_REGS_VH
`define PULSE_SWITCH_REGS_VH

// core clock period in picoseconds
`define CLK_PERIOD_PS     32'd8000
// off timeout in nanoseconds (500 us)
`define OFF_TIMEOUT_NS    32'd500000
// latch delay in nanoseconds (500 us)
`define LATCH_DELAY_NS    32'd500000
// cycles, longest time: rounded down
`define OFF_TIMEOUT_CYC   ((`OFF_TIMEOUT_NS * 32'd1000) / `CLK_PERIOD_PS)
`define LATCH_DELAY_CYC   ((`LATCH_DELAY_NS * 32'd1000) / `CLK_PERIOD_PS)
// width of the timers
`define TIMER_W           17
// default number of switch outputs
`define NUM_SWITCHES      6
// output count that selects the three-output variant
`define THREE_SW          3
// width of the pattern and counter, sized for the six-output variant
`define SW_MAX            6
// counter masks: wrap after eight or sixty-four edges
`define MASK_THREE        6'h07
`define MASK_SIX          6'h3F
// counter value that stands for count one
`define COUNT_FIRST       6'h00
// step of the counter on each rising edge
`define COUNT_STEP        6'h01
// pattern with every switch open
`define PATTERN_NONE      6'h00

`endif

/* verilog/pin_sync.v */
// three-stage synchroniser with agreement filter for the control pin
// assumes an asynchronous pin input and a single core clock
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // raw pin
   input  wire pin_async,
   // filtered level
   output reg  pin_level
);
   reg stage_a;  // first stage, read only by stage_b
   reg stage_b;  // second stage
   reg stage_c;  // third stage

   // shift in; level changes once stages two and three agree
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_a   <= 1'b0;
         stage_b   <= 1'b0;
         stage_c   <= 1'b0;
         pin_level <= 1'b0;
      end else begin
         stage_a <= pin_async;
         stage_b <= stage_a;
         stage_c <= stage_b;
         if (stage_b == stage_c) begin
            pin_level <= stage_c;
         end
      end
   end
endmodule
`default_nettype wire

/* test/pulse_host.sv */
// host gpio model driving the pulse pin
// assumes clk is the decoder clock
`timescale 1ns/1ps
`default_nettype none
module pulse_host (
   input  wire logic clk,
   output var  logic pin
);
   initial pin = 1'b0;
   // n rises with low gaps of g clk; pin is left high
   task automatic burst(input int n, input int g);
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         if (i > 0) begin
            pin <= 1'b0;
            repeat (g) @(posedge clk);
         end
         pin <= 1'b1;
         repeat (5) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

/* test/pulse_switch_checker.sv */
// port assertions for the pulse-count decoder
// assumes one clock domain, rst_n async active low
`timescale 1ns/1ps
`default_nettype none
module pulse_switch_checker #(
   parameter int NUM_SW = 6,
   parameter int LATCH_DELAY_CYC = 20,
   parameter int OFF_TIMEOUT_CYC = 20
) (
   input wire clk,
   input wire rst_n,
   input wire pulse_pin,
   input wire switch_out_a, switch_out_b, switch_out_c,
   input wire switch_out_d, switch_out_e, switch_out_f,
   input wire enabled
);
   wire [5:0] sw = {switch_out_f, switch_out_e, switch_out_d,
                    switch_out_c, switch_out_b, switch_out_a};
   logic [15:0] hi_cnt, lo_cnt; // consecutive raw pin high and low cycles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= 16'h0000;
         lo_cnt <= 16'h0000;
      end else begin
         hi_cnt <= pulse_pin ? hi_cnt + 16'h0001 : 16'h0000;
         lo_cnt <= pulse_pin ? 16'h0000 : lo_cnt + 16'h0001;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rise_idle; $rose(pulse_pin) && !enabled; endsequence
   sequence s_kept_high; pulse_pin [*8]; endsequence
   a_rise_enables: assert property (s_rise_idle |-> ##[1:8] enabled) else $error("no enable");
   a_enable_all_on: assert property ($rose(enabled) |-> sw == (NUM_SW == 3 ? 6'h07 : 6'h3F))
      else $error("not all on");
   a_unused_open: assert property (NUM_SW == 3 |-> sw[5:3] == 3'h0)
      else $error("unused switch on");
   a_off_all_open: assert property (!enabled |-> sw == 6'h00) else $error("on while off");
   a_high_keeps_on: assert property (s_kept_high |=> enabled) else $error("off while high");
   a_off_timeout: assert property (lo_cnt == OFF_TIMEOUT_CYC + 10 |-> !enabled)
      else $error("late shutdown");
   a_no_early_off: assert property ($fell(enabled) |-> lo_cnt >= OFF_TIMEOUT_CYC)
      else $error("early shutdown");
   a_latch_wait: assert property (enabled && $past(enabled) && !$stable(sw)
      |-> hi_cnt >= LATCH_DELAY_CYC) else $error("early latch");
   a_latch_holds: assert property (hi_cnt > LATCH_DELAY_CYC + 10 |-> $stable(sw))
      else $error("pattern moved");
endmodule
`default_nettype wire

/* test/pulse_count_switch_decoder_tb.sv */
// top bench: host model, decoder, bound checker
// assumes host model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module pulse_count_switch_decoder_tb;
   localparam int LAT = 20;
   localparam int OFF = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   wire [5:0] sw, sw3;
   wire en, en3, pin;
   int bad_count = 0, samples_checked = 0, cycles = 0;
   int ns[6] = '{1, 2, 4, 9, 64, 65};
   always #4 clk = ~clk;
   pulse_host i_pulse_host (.clk(clk), .pin(pin));
   pulse_count_switch_decoder #(.NUM_SW(6), .LATCH_DELAY_CYC(LAT), .OFF_TIMEOUT_CYC(OFF))
      i_pulse_count_switch_decoder (.clk(clk), .rst_n(rst_n), .pulse_pin(pin),
      .switch_out_a(sw[0]), .switch_out_b(sw[1]), .switch_out_c(sw[2]), .switch_out_d(sw[3]),
      .switch_out_e(sw[4]), .switch_out_f(sw[5]), .enabled(en));
   pulse_count_switch_decoder #(.NUM_SW(3), .LATCH_DELAY_CYC(LAT), .OFF_TIMEOUT_CYC(OFF))
      i_pulse_count_switch_decoder_three (.clk(clk), .rst_n(rst_n), .pulse_pin(pin),
      .switch_out_a(sw3[0]), .switch_out_b(sw3[1]), .switch_out_c(sw3[2]),
      .switch_out_d(sw3[3]), .switch_out_e(sw3[4]), .switch_out_f(sw3[5]), .enabled(en3));
   task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // n rises from disabled, hold for latch, then drop and time out
   task automatic t_pattern(input int n, input int g);
      i_pulse_host.burst(n, g);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("all on", sw, 6'h3F);
      check("all on three", sw3, 6'h07);
      repeat (LAT + 15) @(posedge clk);
      @(negedge clk);
      check("pattern", sw, ~6'(n - 1));
      check("pattern three", sw3, {3'h0, ~3'(n - 1)});
      @(posedge clk) i_pulse_host.pin <= 1'b0;
      repeat (OFF - 4) @(posedge clk);
      @(negedge clk);
      check("enabled", {4'h0, en3, en}, 6'h03);
      repeat (20) @(posedge clk);
      @(negedge clk);
      check("enabled", {4'h0, en3, en}, 6'h00);
      check("off", sw, 6'h00);
      check("off three", sw3, 6'h00);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ns[i]) t_pattern(ns[i], i == 1 ? 15 : 5);
      end_sim();
   end
endmodule
bind pulse_count_switch_decoder pulse_switch_checker #(.NUM_SW(NUM_SW),
   .LATCH_DELAY_CYC(LATCH_DELAY_CYC),
   .OFF_TIMEOUT_CYC(OFF_TIMEOUT_CYC)) i_pulse_switch_checker (.clk(clk), .rst_n(rst_n),
   .pulse_pin(pulse_pin), .switch_out_a(switch_out_a), .switch_out_b(switch_out_b),
   .switch_out_c(switch_out_c), .switch_out_d(switch_out_d), .switch_out_e(switch_out_e),
   .switch_out_f(switch_out_f), .enabled(enabled));
`default_nettype wire
